// File: orc_regs.v
// Option, interrupt mask and PWM control register bank on APB
// Assumes an APB master on mclk; peripherals consume the field outputs
//
// Overview of operation
// [R1] Trim register bits 7..5 store nothing and read zero.
// [R2] Trim code bits 4..0 reset to 11111, nominal frequency.
// [R3] Second option register bits 7..6 ignore writes, read zero.
// [R4] Bits 5..4 select undervolt reset level; 11 is power-on only.
// [R5] Bits 3..2 select oscillator frequency; 11, 4 MHz, is default.
// [R6] Converter bit-select bit 1 is held at zero always.
// [R7] Bit 0 selects watchdog period; one, 18 ms, is default.
// [R8] Each interrupt source enabled only when its mask bit is one.
// [R9] Global enable set and cleared by instructions; both needed.
// [R10] Mask bits: 7 cmp, 5 pwm b, 4 pwm a, 3 adc, 2 ext, 1 port, 0 tmr.
// [R11] Mask bit 6 is unused, ignores writes, reads zero.
// [R12] Software enables a source's mask bit before relying on it.
// [R13] PWM control bits 7..3 store nothing and read zero.
// [R14] PWM bit 2 selects cascade; zero gives two 8-bit channels.
// [R15] PWM bit 1 enables channel b; pin forced to output.
// [R16] PWM bit 0 enables channel a; pin driven as output.
// [R17] Reset loads stated defaults; the rest, interrupt enables too, zero.
`timescale 1ns/1ps
`include "orc_regs_defs.vh"

module orc_regs #(
  parameter DW = `ORC_DATA_W
) (
  // Clock and reset
  input  wire          mclk,
  input  wire          sys_rst,
  // APB slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  // Core instruction strobes
  input  wire          global_irq_on_instr,
  input  wire          global_irq_off_instr,
  // Interrupt source flags
  input  wire [DW-1:0] irq_flags,
  // Oscillator trim and option fields
  output wire [4:0]    osc_trim_code,
  output wire          undervolt_level_hi,
  output wire          undervolt_level_lo,
  output wire          osc_freq_sel_hi,
  output wire          osc_freq_sel_lo,
  output wire          converter_bit_sel,
  output wire          watchdog_period_sel,
  // Interrupt enables
  output wire          comparator_irq_en,
  output wire          pwm_b_irq_en,
  output wire          pwm_a_irq_en,
  output wire          conversion_done_irq_en,
  output wire          ext_pin_irq_en,
  output wire          port_change_irq_en,
  output wire          timer_overflow_irq_en,
  output wire          global_irq_en,
  output wire          irq_req,
  // PWM control
  output wire          pwm_cascade_sel,
  output wire          pwm_b_enable,
  output wire          pwm_a_enable,
  output wire          port_pin_six_force_out,
  output wire          port_pin_one_force_out
);

  reg  [DW-1:0] osc_trim_reg;
  reg  [DW-1:0] osc_trim_next;
  reg  [DW-1:0] sys_opt_reg;
  reg  [DW-1:0] sys_opt_next;
  reg  [DW-1:0] irq_mask_reg;
  reg  [DW-1:0] irq_mask_next;
  reg  [DW-1:0] pwm_ctrl_reg;
  reg  [DW-1:0] pwm_ctrl_next;
  reg           gie_reg;
  reg           gie_next;
  reg  [31:0]   rdata_next;
  wire [DW-1:0] irq_pending;
  wire          wr_acc;
  wire          rd_acc;
  wire [DW-1:0] wbyte;

  // Masked register update, used for every writable register but the global enable
  function [DW-1:0] merge_wr;
    input [DW-1:0] old_val;
    input [DW-1:0] new_val;
    input [DW-1:0] wmask;
    input          hit;
    begin
      if (hit) begin
        merge_wr = new_val & wmask;
      end else begin
        merge_wr = old_val & wmask;
      end
    end
  endfunction

  // Zero-extend a byte onto the 32-bit bus
  function [31:0] ext32;
    input [DW-1:0] v;
    begin
      ext32 = `ORC_ZERO32 | {{(32-DW){1'b0}}, v};
    end
  endfunction

  // Zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & ~penable & ~pwrite;
  assign wbyte   = pwdata[DW-1:0];

  // Next-state for the register bank
  always @* begin
    osc_trim_next = merge_wr(osc_trim_reg, wbyte, `ORC_MASK_OSC_TRIM,
      wr_acc && paddr == `ORC_ADDR_OSC_TRIM); // [R1] [R2]
    sys_opt_next  = merge_wr(sys_opt_reg, wbyte, `ORC_MASK_SYS_OPT,
      wr_acc && paddr == `ORC_ADDR_SYS_OPT); // [R3] [R4] [R5] [R6] [R7]
    irq_mask_next = merge_wr(irq_mask_reg, wbyte, `ORC_MASK_IRQ_MASK,
      wr_acc && paddr == `ORC_ADDR_IRQ_MASK); // [R10] [R11]
    pwm_ctrl_next = merge_wr(pwm_ctrl_reg, wbyte, `ORC_MASK_PWM_CTRL,
      wr_acc && paddr == `ORC_ADDR_PWM_CTRL); // [R13] [R14]
    // Instruction strobes; enable wins if both come together
    gie_next = gie_reg;
    if (global_irq_off_instr) begin
      gie_next = 1'b0; // [R9]
    end
    if (global_irq_on_instr) begin
      gie_next = 1'b1; // [R9]
    end
    if (wr_acc && paddr == `ORC_ADDR_GIE) begin
      gie_next = wbyte[0];
    end
  end

  // Register state, loaded with defaults on reset
  always @(posedge mclk) begin
    if (sys_rst) begin
      osc_trim_reg <= `ORC_RST_OSC_TRIM; // [R17] [R2]
      sys_opt_reg  <= `ORC_RST_SYS_OPT;  // [R17] [R5] [R7]
      irq_mask_reg <= `ORC_RST_IRQ_MASK; // [R17]
      pwm_ctrl_reg <= `ORC_RST_PWM_CTRL; // [R17]
      gie_reg      <= 1'b0;              // [R17]
    end else begin
      osc_trim_reg <= osc_trim_next;
      sys_opt_reg  <= sys_opt_next;
      irq_mask_reg <= irq_mask_next;
      pwm_ctrl_reg <= pwm_ctrl_next;
      gie_reg      <= gie_next;
    end
  end

  // Read mux; data latched in setup so it is stable in the access cycle
  always @* begin
    rdata_next = prdata;
    if (rd_acc) begin
      case (paddr)
        `ORC_ADDR_OSC_TRIM: rdata_next = ext32(osc_trim_reg);
        `ORC_ADDR_SYS_OPT:  rdata_next = ext32(sys_opt_reg);
        `ORC_ADDR_IRQ_MASK: rdata_next = ext32(irq_mask_reg);
        `ORC_ADDR_PWM_CTRL: rdata_next = ext32(pwm_ctrl_reg);
        `ORC_ADDR_GIE:      rdata_next = ext32({{(DW-1){1'b0}}, gie_reg});
        `ORC_ADDR_IRQ_STAT: rdata_next = ext32(irq_pending);
        default:            rdata_next = `ORC_ZERO32;
      endcase
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= `ORC_ZERO32;
    end else begin
      prdata <= rdata_next;
    end
  end

  // Interrupt gating; software must have set the mask bit first
  orc_irq_gate #(
    .W (DW)
  ) u_gate (
    .irq_mask    (irq_mask_reg), // [R12]
    .global_en   (gie_reg),
    .irq_flags   (irq_flags),
    .irq_pending (irq_pending),
    .irq_req     (irq_req)
  );

  // Field outputs
  assign osc_trim_code       = osc_trim_reg[`ORC_TRIM_HI:`ORC_TRIM_LO]; // [R2]
  assign undervolt_level_hi  = sys_opt_reg[`ORC_LVR_HI]; // [R4]
  assign undervolt_level_lo  = sys_opt_reg[`ORC_LVR_LO]; // [R4]
  assign osc_freq_sel_hi     = sys_opt_reg[`ORC_RCM_HI]; // [R5]
  assign osc_freq_sel_lo     = sys_opt_reg[`ORC_RCM_LO]; // [R5]
  assign converter_bit_sel   = 1'b0; // [R6]
  assign watchdog_period_sel = sys_opt_reg[`ORC_WDT_BIT]; // [R7]

  assign comparator_irq_en      = irq_mask_reg[`ORC_IRQ_CMP];   // [R10]
  assign pwm_b_irq_en           = irq_mask_reg[`ORC_IRQ_PWM_B]; // [R10]
  assign pwm_a_irq_en           = irq_mask_reg[`ORC_IRQ_PWM_A]; // [R10]
  assign conversion_done_irq_en = irq_mask_reg[`ORC_IRQ_ADC];   // [R10]
  assign ext_pin_irq_en         = irq_mask_reg[`ORC_IRQ_EXT];   // [R10]
  assign port_change_irq_en     = irq_mask_reg[`ORC_IRQ_PORT];  // [R10]
  assign timer_overflow_irq_en  = irq_mask_reg[`ORC_IRQ_TMR];   // [R10]
  assign global_irq_en          = gie_reg; // [R9]

  // Channel enables also take the shared pins over as outputs
  assign pwm_cascade_sel        = pwm_ctrl_reg[`ORC_PWM_CAS_BIT]; // [R14]
  assign pwm_b_enable           = pwm_ctrl_reg[`ORC_PWM_B_BIT];   // [R15]
  assign pwm_a_enable           = pwm_ctrl_reg[`ORC_PWM_A_BIT];   // [R16]
  assign port_pin_six_force_out = pwm_ctrl_reg[`ORC_PWM_B_BIT];   // [R15]
  assign port_pin_one_force_out = pwm_ctrl_reg[`ORC_PWM_A_BIT];   // [R16]

endmodule // orc_regs

// File: orc_regs_defs.vh
// Register offsets, field positions, reset values for the option bank
// Included by the register bank and its interrupt gate
`ifndef ORC_REGS_DEFS_VH
`define ORC_REGS_DEFS_VH

// Byte addresses on the APB window
`define ORC_ADDR_OSC_TRIM    8'h00
`define ORC_ADDR_SYS_OPT     8'h04
`define ORC_ADDR_IRQ_MASK    8'h08
`define ORC_ADDR_PWM_CTRL    8'h0c
`define ORC_ADDR_GIE         8'h10
`define ORC_ADDR_IRQ_STAT    8'h14

// Writable masks (reserved bits never stored)
`define ORC_MASK_OSC_TRIM    8'h1f
`define ORC_MASK_SYS_OPT     8'h3d
`define ORC_MASK_IRQ_MASK    8'hbf
`define ORC_MASK_PWM_CTRL    8'h07

// Reset values
`define ORC_RST_OSC_TRIM     8'h1f
`define ORC_RST_SYS_OPT      8'h0d
`define ORC_RST_IRQ_MASK     8'h00
`define ORC_RST_PWM_CTRL     8'h00

// Trim code field in the oscillator trim register
`define ORC_TRIM_HI          4
`define ORC_TRIM_LO          0

// Field positions in the second option register
`define ORC_LVR_HI           5
`define ORC_LVR_LO           4
`define ORC_RCM_HI           3
`define ORC_RCM_LO           2
`define ORC_WDT_BIT          0

// Field positions in the PWM control register
`define ORC_PWM_CAS_BIT      2
`define ORC_PWM_B_BIT        1
`define ORC_PWM_A_BIT        0

// Interrupt mask bit positions
`define ORC_IRQ_CMP          7
`define ORC_IRQ_PWM_B        5
`define ORC_IRQ_PWM_A        4
`define ORC_IRQ_ADC          3
`define ORC_IRQ_EXT          2
`define ORC_IRQ_PORT         1
`define ORC_IRQ_TMR          0

`define ORC_DATA_W           8
`define ORC_ZERO32           32'h00000000

`endif

// File: orc_irq_gate.v
// Interrupt gate: per-source enable AND global enable
// Assumes flags arrive as levels from peripherals outside this bank
`timescale 1ns/1ps
`include "orc_regs_defs.vh"

module orc_irq_gate #(
  parameter W = 8
) (
  // Enables
  input  wire [W-1:0] irq_mask,
  input  wire         global_en,
  // Source flags
  input  wire [W-1:0] irq_flags,
  // Result
  output wire [W-1:0] irq_pending,
  output wire         irq_req
);

  genvar i;
  // One gate per source; bit 6 mask is always zero so it never fires
  generate
    for (i = 0; i < W; i = i + 1) begin : g_src
      assign irq_pending[i] = irq_flags[i] & irq_mask[i]; // [R8]
    end
  endgenerate

  // Request only with both enables active
  assign irq_req = global_en & (|irq_pending); // [R9]

endmodule // orc_irq_gate

// File: orc_regs_monitor.sv
// Checker for the option, mask and PWM control register bank
// Assumes it is bound to orc_regs and sees only its ports
`timescale 1ns/1ps
module orc_regs_monitor (
  // Clock, reset, bus
  input wire        mclk,
  input wire        sys_rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  // Core strobes and flags
  input wire        global_irq_on_instr,
  input wire        global_irq_off_instr,
  input wire [7:0]  irq_flags,
  // Field outputs
  input wire [4:0]  osc_trim_code,
  input wire        undervolt_level_hi,
  input wire        undervolt_level_lo,
  input wire        osc_freq_sel_hi,
  input wire        osc_freq_sel_lo,
  input wire        converter_bit_sel,
  input wire        watchdog_period_sel,
  input wire        comparator_irq_en,
  input wire        pwm_b_irq_en,
  input wire        pwm_a_irq_en,
  input wire        conversion_done_irq_en,
  input wire        ext_pin_irq_en,
  input wire        port_change_irq_en,
  input wire        timer_overflow_irq_en,
  input wire        global_irq_en,
  input wire        irq_req,
  input wire        pwm_cascade_sel,
  input wire        pwm_b_enable,
  input wire        pwm_a_enable,
  input wire        port_pin_six_force_out,
  input wire        port_pin_one_force_out
);
  // Mask enables in register order; bit 6 has no output
  wire [7:0] en_v = {comparator_irq_en, 1'b0, pwm_b_irq_en, pwm_a_irq_en,
    conversion_done_irq_en, ext_pin_irq_en, port_change_irq_en,
    timer_overflow_irq_en};
  wire       wr = psel && penable && pwrite;
  wire       gwr = wr && paddr == 8'h10; // Bus write beats the strobes

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  trim_store_a: assert property (wr && paddr == 8'h00 |=>
    osc_trim_code == $past(pwdata[4:0])) else $error("trim not stored");
  opt_store_a: assert property (wr && paddr == 8'h04 |=>
    {undervolt_level_hi, undervolt_level_lo, osc_freq_sel_hi,
     osc_freq_sel_lo} == $past(pwdata[5:2]) &&
    watchdog_period_sel == $past(pwdata[0])) else $error("option lost");
  bitsel_zero_a: assert property (converter_bit_sel == 1'b0)
    else $error("converter select not zero");
  mask_store_a: assert property (wr && paddr == 8'h08 |=>
    en_v == ($past(pwdata[7:0]) & 8'hbf)) else $error("mask not stored");
  pwm_store_a: assert property (wr && paddr == 8'h0c |=>
    {pwm_cascade_sel, pwm_b_enable, pwm_a_enable} == $past(pwdata[2:0]))
    else $error("pwm control not stored");
  pin_force_a: assert property ({port_pin_six_force_out,
    port_pin_one_force_out} == {pwm_b_enable, pwm_a_enable})
    else $error("pin force mismatch");
  irq_gate_a: assert property (irq_req ==
    ((|(irq_flags & en_v)) && global_irq_en)) else $error("irq gate");
  gie_on_a: assert property (global_irq_on_instr && !gwr |=>
    global_irq_en) else $error("global enable not set");
  gie_off_a: assert property (global_irq_off_instr &&
    !global_irq_on_instr && !gwr |=> !global_irq_en)
    else $error("global enable not cleared");
  rd_zero_a: assert property (
    psel && penable && !pwrite |->
    prdata[31:8] == 24'h000000 && !(paddr == 8'h00 && |prdata[7:5]) &&
    !(paddr == 8'h04 && (|prdata[7:6] || prdata[1])) &&
    !(paddr == 8'h08 && prdata[6]) && !(paddr == 8'h0c && |prdata[7:3]))
    else $error("reserved bits read nonzero");
  rst_dflt_a: assert property ($fell(sys_rst) |->
    osc_trim_code == 5'h1f && watchdog_period_sel && osc_freq_sel_hi &&
    osc_freq_sel_lo && !undervolt_level_hi && !undervolt_level_lo &&
    en_v == 8'h00 && !global_irq_en && !pwm_a_enable && !pwm_b_enable &&
    !pwm_cascade_sel)
    else $error("reset defaults wrong");
endmodule // orc_regs_monitor

bind orc_regs orc_regs_monitor mon_u (.*);

// File: orc_regs_test.sv
// Self-checking bench for the register bank over APB
// Assumes the checker is bound in from its own file
`timescale 1ns/1ps
module orc_regs_test;
  // Defaults per address, and stored bits per register
  localparam [39:0] DFLT = 40'h00_00_00_0d_1f;
  localparam [31:0] WMSK = 32'h07_bf_3d_1f;
  reg         mclk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h00000000;
  reg         g_on = 1'b0;
  reg         g_off = 1'b0;
  reg  [7:0]  irq_flags = 8'h00;
  reg  [31:0] q;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire [4:0]  trim;
  wire [3:0]  opt;
  wire [4:0]  pwm;
  wire        wdt;
  wire        gie;
  wire        irq_req;
  integer     errors = 0;
  integer     n_compared = 0;
  integer     i;

  always #12.5 mclk = ~mclk;

  orc_regs dut_u (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_on_instr(g_on), .global_irq_off_instr(g_off),
    .irq_flags(irq_flags), .osc_trim_code(trim),
    .undervolt_level_hi(opt[3]), .undervolt_level_lo(opt[2]),
    .osc_freq_sel_hi(opt[1]), .osc_freq_sel_lo(opt[0]),
    .converter_bit_sel(), .watchdog_period_sel(wdt),
    .comparator_irq_en(), .pwm_b_irq_en(), .pwm_a_irq_en(),
    .conversion_done_irq_en(), .ext_pin_irq_en(), .port_change_irq_en(),
    .timer_overflow_irq_en(), .global_irq_en(gie), .irq_req(irq_req),
    .pwm_cascade_sel(pwm[4]), .pwm_b_enable(pwm[3]), .pwm_a_enable(pwm[2]),
    .port_pin_six_force_out(pwm[1]), .port_pin_one_force_out(pwm[0]));

  task check(input string what, input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("Error %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  // One APB transfer; waits on pready, never a fixed count
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Strobe pulse, then let the edge that takes it land
  task pulse(input on);
    begin
      @(posedge mclk);
      if (on) g_on <= 1'b1;
      else g_off <= 1'b1;
      @(posedge mclk);
      g_on <= 1'b0;
      g_off <= 1'b0;
      #1;
    end
  endtask

  task defaults;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        apb(1'b0, i * 4, 32'h0);
        check("default", q, {24'h0, DFLT[8*i +: 8]});
      end
    end
  endtask

  task close_out;
    begin
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    errors = errors + 1;
    close_out;
  end

  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    defaults;
    // Reserved bits dropped, stored bits read back
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, i * 4, 32'hffffffff);
      apb(1'b0, i * 4, 32'h0);
      check("stored", q, {24'h0, WMSK[8*i+:8]});
      apb(1'b1, i * 4, 32'h0);
    end
    // Every level and frequency code, watchdog both ways
    // Outputs are flops loaded at the write edge: look after it settles
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, 8'h04, (i << 4) | ((3 - i) << 2) | (i & 1));
      #1;
      check("option", {wdt, opt}, {i[0], i[1:0], ~i[1:0]});
    end
    apb(1'b1, 8'h00, 32'h000000f0);
    #1;
    check("trim", trim, 5'h10);
    apb(1'b1, 8'h20, 32'hffffffff);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped", q, 32'h0);
    check("slverr", pslverr, 1'b0);
    // One mask bit at a time against its own flag and the others
    pulse(1'b1);
    for (i = 0; i < 8; i = i + 1) begin
      apb(1'b1, 8'h08, 1 << i);
      irq_flags <= 1 << i;
      @(posedge mclk);
      #1;
      check("irq own", irq_req, i != 6);
      irq_flags <= ~(8'h01 << i);
      @(posedge mclk);
      #1;
      check("irq other", irq_req, 1'b0);
    end
    apb(1'b1, 8'h08, 32'hff);
    pulse(1'b0);
    check("gie off", {gie, irq_req}, 2'b00);
    pulse(1'b1);
    check("gie on", {gie, irq_req}, 2'b11);
    apb(1'b1, 8'h10, 32'h0);
    #1;
    check("gie bus", gie, 1'b0);
    // PWM enables and pin forcing
    apb(1'b1, 8'h0c, 32'h5);
    #1;
    check("pwm", pwm, 5'b10101);
    apb(1'b1, 8'h0c, 32'h2);
    #1;
    check("pwm", pwm, 5'b01010);
    // Reset in mid-run restores defaults
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    defaults;
    check("gie reset", {gie, pwm}, 6'h00);
    close_out;
  end
endmodule // orc_regs_test
